/* File: core/pioc_top.sv */
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/100ps
`include "pioc_consts.svh"
// Functional notes
// - Filter-disable write ones deselect glitch filter per pin, any owner
// - Filter status reads selected filters, resets zero, covers both paths
// - Filtered value holds its state while the clock is stopped
// - Set-output write ones set stored data; drive only if owned and enabled
// - Clear-output write ones clear stored data, same drive conditions
// - Output data status reads stored data, resets zero
// - Pin level status shows the pin level, after the glitch filter where it is selected
// - Irq-enable write ones enable change interrupt, any owner
// - Irq-disable write ones mask interrupt; changes still recorded
// - Irq mask reflects enables and disables, resets zero
// - Irq status sets on any edge of any pin's level after the glitch filter where selected, any owner or direction
// - Reading irq status clears it; reset clears it too
// - Open-drain enable write ones make pin driver open-drain
// - Open-drain disable write ones restore push-pull drive
// - Open-drain status reads open-drain pins, resets zero
// - Peripheral input held at zero while pin is under controller
// - Output enable stored always, effective only under controller
// - First irq status read after reset may show changes since reset
module pioc_top #(
	parameter int WIDTH = 32
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic [7:0]       i_avs_address,
	input  wire logic             i_avs_read,
	input  wire logic             i_avs_write,
	input  wire logic [31:0]      i_avs_writedata,
	output logic      [31:0]      o_avs_readdata,
	output logic                  o_avs_waitrequest,
	input  wire logic [WIDTH-1:0] i_pin,
	output logic      [WIDTH-1:0] o_pin,
	output logic      [WIDTH-1:0] o_pin_oe_n,
	input  wire logic [WIDTH-1:0] i_periph_out,
	input  wire logic [WIDTH-1:0] i_periph_oe,
	output logic      [WIDTH-1:0] o_periph_in,
	output logic                  o_irq
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
		$error("WIDTH must be 1 to 32");
	end

	// Reset words cut to the pin count on purpose
	localparam logic [WIDTH-1:0] RST_ZERO_W = WIDTH'(`PIOC_RST_ZERO);
	localparam logic [WIDTH-1:0] RST_OWN_W  = WIDTH'(`PIOC_RST_OWN);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Set and clear strobes applied to a per-pin register
	function automatic logic [WIDTH-1:0] set_clr(
		input logic [WIDTH-1:0] cur,
		input logic             do_set,
		input logic             do_clr,
		input logic [WIDTH-1:0] bits
	);
		logic [WIDTH-1:0] r;
		r = cur;
		if (do_set) begin
			r = r | bits;
		end
		if (do_clr) begin
			r = r & ~bits;
		end
		return r;
	endfunction

	// Widen a pin vector into a bus word, upper bits zero
	function automatic logic [31:0] widen(input logic [WIDTH-1:0] v);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[WIDTH-1:0] = v;
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Bus request decode
	// ----------------------------------------------------------------
	pioc_pkg::pioc_req_type req;
	pioc_pkg::pioc_bus_type bus_q;
	pioc_pkg::pioc_bus_type bus_d;
	logic                   wr_go;
	logic                   rd_go;
	logic [WIDTH-1:0]       wbits;

	// One wait cycle, then accept; write effects land at that same edge
	always_comb begin
		req.addr  = i_avs_address;
		req.rd    = i_avs_read;
		req.wr    = i_avs_write;
		req.wdata = i_avs_writedata;
		wbits     = req.wdata[WIDTH-1:0];
		wr_go     = req.wr && (bus_q == pioc_pkg::PIOC_DONE);
		rd_go     = req.rd && (bus_q == pioc_pkg::PIOC_DONE);
		case (bus_q)
			pioc_pkg::PIOC_IDLE: begin
				bus_d = (req.rd || req.wr) ? pioc_pkg::PIOC_DONE
				                           : pioc_pkg::PIOC_IDLE;
			end
			pioc_pkg::PIOC_DONE: begin
				bus_d = pioc_pkg::PIOC_IDLE;
			end
			default: begin
				bus_d = pioc_pkg::PIOC_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] own_q, own_d;
	logic [WIDTH-1:0] drv_q, drv_d;
	logic [WIDTH-1:0] flt_q, flt_d;
	logic [WIDTH-1:0] odat_q, odat_d;
	logic [WIDTH-1:0] mask_q, mask_d;
	logic [WIDTH-1:0] od_q, od_d;

	// Each pair of write-only strobes edits one status vector
	always_comb begin
		own_d  = set_clr(own_q, wr_go && req.addr == `PIOC_OFS_OWN_EN,
		                 wr_go && req.addr == `PIOC_OFS_OWN_DIS, wbits);
		drv_d  = set_clr(drv_q, wr_go && req.addr == `PIOC_OFS_DRV_EN,
		                 wr_go && req.addr == `PIOC_OFS_DRV_DIS,
		                 wbits);
		flt_d  = set_clr(flt_q, wr_go && req.addr == `PIOC_OFS_FLT_EN,
		                 wr_go && req.addr == `PIOC_OFS_FLT_DIS,
		                 wbits);
		odat_d = set_clr(odat_q, wr_go && req.addr == `PIOC_OFS_OUT_SET,
		                 wr_go && req.addr == `PIOC_OFS_OUT_CLR,
		                 wbits);
		mask_d = set_clr(mask_q, wr_go && req.addr == `PIOC_OFS_IRQ_EN,
		                 wr_go && req.addr == `PIOC_OFS_IRQ_DIS,
		                 wbits);
		od_d   = set_clr(od_q, wr_go && req.addr == `PIOC_OFS_OD_EN,
		                 wr_go && req.addr == `PIOC_OFS_OD_DIS,
		                 wbits);
	end

	// Controller owns all pins after reset, as inputs
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			bus_q  <= pioc_pkg::PIOC_IDLE;
			own_q  <= RST_OWN_W;
			drv_q  <= RST_ZERO_W;
			flt_q  <= RST_ZERO_W;
			odat_q <= RST_ZERO_W;
			mask_q <= RST_ZERO_W;
			od_q   <= RST_ZERO_W;
		end else begin
			bus_q  <= bus_d;
			own_q  <= own_d;
			drv_q  <= drv_d;
			flt_q  <= flt_d;
			odat_q <= odat_d;
			mask_q <= mask_d;
			od_q   <= od_d;
		end
	end

	// Write strobes must reach the vectors they name at the accept edge
	a_flt_disable: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_go && req.addr == `PIOC_OFS_FLT_DIS |=>
		(flt_q & $past(wbits)) == '0)
		else $error("filter disable ignored");
	a_out_set: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_go && req.addr == `PIOC_OFS_OUT_SET |=>
		(odat_q & $past(wbits)) == $past(wbits))
		else $error("output set ignored");
	a_out_clear: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_go && req.addr == `PIOC_OFS_OUT_CLR |=>
		(odat_q & $past(wbits)) == '0)
		else $error("output clear ignored");
	a_mask_track: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_go && req.addr == `PIOC_OFS_IRQ_EN |=>
		(mask_q & $past(wbits)) == $past(wbits))
		else $error("irq enable ignored");
	a_mask_clear: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_go && req.addr == `PIOC_OFS_IRQ_DIS |=>
		(mask_q & $past(wbits)) == '0)
		else $error("irq disable ignored");
	a_od_set: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_go && req.addr == `PIOC_OFS_OD_EN |=>
		(od_q & $past(wbits)) == $past(wbits))
		else $error("open drain enable ignored");
	a_od_clear: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_go && req.addr == `PIOC_OFS_OD_DIS |=>
		(od_q & $past(wbits)) == '0)
		else $error("open drain disable ignored");

	// ----------------------------------------------------------------
	// Input path: sample, filter, detect change
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] smp_q, smp_d;
	logic [WIDTH-1:0] lvl_q, lvl_d;
	logic [WIDTH-1:0] prev_q, prev_d;
	logic [WIDTH-1:0] isr_q, isr_d;
	logic             prev_ok_q;

	// A filtered pin only moves once a level is seen on two edges;
	// registers simply hold when the clock stops, which freezes it
	for (genvar g = 0; g < WIDTH; g++) begin : g_flt
		always_comb begin
			smp_d[g] = i_pin[g];
			if (flt_q[g]) begin
				lvl_d[g] = (smp_q[g] == i_pin[g]) ? i_pin[g]
				                                  : lvl_q[g];
			end else begin
				lvl_d[g] = i_pin[g];
			end
		end
	end

	// Status sets on any change; a read clears, but a same-cycle edge wins
	always_comb begin
		// Seed from the live level on the first edge after reset, so the
		// zero reset value of lvl_q is never mistaken for a pin edge
		prev_d = prev_ok_q ? lvl_q : lvl_d;
		isr_d  = isr_q;
		if (rd_go && req.addr == `PIOC_OFS_IRQ_STAT) begin
			isr_d = '0;
		end
		if (prev_ok_q) begin
			isr_d = isr_d | (lvl_q ^ prev_q);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			smp_q     <= RST_ZERO_W;
			lvl_q     <= RST_ZERO_W;
			prev_q    <= RST_ZERO_W;
			isr_q     <= RST_ZERO_W;
			prev_ok_q <= 1'b0;
		end else begin
			smp_q     <= smp_d;
			lvl_q     <= lvl_d;
			prev_q    <= prev_d;
			isr_q     <= isr_d;
			prev_ok_q <= 1'b1;
		end
	end

	// Level tracking, filtering and change capture
	a_pin_follow: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_rst_n |=>
		((lvl_q ^ $past(i_pin)) & ~$past(flt_q)) == '0)
		else $error("unfiltered level stale");
	a_filter_hold: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_rst_n |=> ((lvl_q ^ $past(lvl_q)) & $past(flt_q)
		& ($past(smp_q) ^ $past(i_pin))) == '0)
		else $error("glitch passed filter");
	a_edge_record: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		prev_ok_q && (lvl_q != prev_q) |=>
		(isr_q & ($past(lvl_q) ^ $past(prev_q)))
		== ($past(lvl_q) ^ $past(prev_q)))
		else $error("edge not recorded");
	a_read_clear: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		rd_go && req.addr == `PIOC_OFS_IRQ_STAT |=>
		(isr_q & ~($past(lvl_q) ^ $past(prev_q))) == '0)
		else $error("status not cleared");

	// ----------------------------------------------------------------
	// Pin drive, peripheral input, interrupt and read data
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] pin_d, oe_n_d, pin_q, oe_n_q, per_q, per_d;
	logic             irq_d, irq_q;
	logic [31:0]      rdat_d, rdat_q;
	logic             wait_d, wait_q;
	logic [WIDTH-1:0] val, en;

	// Open-drain pins only pull low; high is left to the wire
	always_comb begin
		val    = (own_q & odat_q) | (~own_q & i_periph_out);
		en     = (own_q & drv_q) | (~own_q & i_periph_oe);
		pin_d  = val;
		oe_n_d = ~(en & ~(od_q & val));
		per_d  = lvl_q & ~own_q;
		irq_d  = |(isr_d & mask_d);
		wait_d = !(bus_d == pioc_pkg::PIOC_DONE);
		rdat_d = 32'h0000_0000;
		if (bus_d == pioc_pkg::PIOC_DONE && req.rd) begin
			case (req.addr)
				`PIOC_OFS_OWN_STAT:  rdat_d = widen(own_q);
				`PIOC_OFS_DRV_STAT:  rdat_d = widen(drv_q);
				`PIOC_OFS_FLT_STAT:  rdat_d = widen(flt_q);
				`PIOC_OFS_OUT_STAT:  rdat_d = widen(odat_q);
				`PIOC_OFS_PIN_STAT:  rdat_d = widen(lvl_q);
				`PIOC_OFS_IRQ_MASK:  rdat_d = widen(mask_q);
				`PIOC_OFS_IRQ_STAT:  rdat_d = widen(isr_d);
				`PIOC_OFS_OD_STAT:   rdat_d = widen(od_q);
				default:             rdat_d = 32'h0000_0000;
			endcase
		end
	end

	// All outputs are registered; read data is captured one edge early
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pin_q  <= RST_ZERO_W;
			oe_n_q <= RST_OWN_W;
			per_q  <= RST_ZERO_W;
			irq_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
			wait_q <= 1'b1;
		end else begin
			pin_q  <= pin_d;
			oe_n_q <= oe_n_d;
			per_q  <= per_d;
			irq_q  <= irq_d;
			rdat_q <= rdat_d;
			wait_q <= wait_d;
		end
	end

	assign o_pin             = pin_q;
	assign o_pin_oe_n        = oe_n_q;
	assign o_periph_in       = per_q;
	assign o_irq             = irq_q;
	assign o_avs_readdata    = rdat_q;
	assign o_avs_waitrequest = wait_q;

	// ----------------------------------------------------------------
	// Output and read-back checks
	// ----------------------------------------------------------------
	a_irq_out: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		##1 o_irq == |($past(isr_d) & $past(mask_d)))
		else $error("irq request wrong");
	a_periph_zero: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		##1 (o_periph_in & $past(own_q)) == '0)
		else $error("peripheral input not held low");
	a_periph_follow: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_rst_n |=>
		((o_periph_in ^ $past(lvl_q)) & ~$past(own_q)) == '0)
		else $error("peripheral input not following pin");
	a_od_high: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		##1 (~o_pin_oe_n & o_pin & $past(od_q)) == '0)
		else $error("open drain drove high");
	// Read data at the accept edge carries the vector it names
	a_flt_read: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		rd_go && req.addr == `PIOC_OFS_FLT_STAT |->
		o_avs_readdata[WIDTH-1:0] == flt_q)
		else $error("filter status misread");
	a_out_read: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		rd_go && req.addr == `PIOC_OFS_OUT_STAT |->
		o_avs_readdata[WIDTH-1:0] == odat_q)
		else $error("output status misread");
	a_pin_read: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		rd_go && req.addr == `PIOC_OFS_PIN_STAT |->
		o_avs_readdata[WIDTH-1:0] == $past(lvl_q))
		else $error("pin status misread");
	a_mask_read: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		rd_go && req.addr == `PIOC_OFS_IRQ_MASK |->
		o_avs_readdata[WIDTH-1:0] == mask_q)
		else $error("irq mask misread");
	a_od_read: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		rd_go && req.addr == `PIOC_OFS_OD_STAT |->
		o_avs_readdata[WIDTH-1:0] == od_q)
		else $error("open drain status misread");

endmodule

/* File: core/pioc_consts.svh */
`ifndef PIOC_CONSTS_SVH
`define PIOC_CONSTS_SVH
// Register byte offsets
`define PIOC_OFS_OWN_EN    8'h00
`define PIOC_OFS_OWN_DIS   8'h04
`define PIOC_OFS_OWN_STAT  8'h08
`define PIOC_OFS_DRV_EN    8'h10
`define PIOC_OFS_DRV_DIS   8'h14
`define PIOC_OFS_DRV_STAT  8'h18
`define PIOC_OFS_FLT_EN    8'h20
`define PIOC_OFS_FLT_DIS   8'h24
`define PIOC_OFS_FLT_STAT  8'h28
`define PIOC_OFS_OUT_SET   8'h30
`define PIOC_OFS_OUT_CLR   8'h34
`define PIOC_OFS_OUT_STAT  8'h38
`define PIOC_OFS_PIN_STAT  8'h3c
`define PIOC_OFS_IRQ_EN    8'h40
`define PIOC_OFS_IRQ_DIS   8'h44
`define PIOC_OFS_IRQ_MASK  8'h48
`define PIOC_OFS_IRQ_STAT  8'h4c
`define PIOC_OFS_OD_EN     8'h50
`define PIOC_OFS_OD_DIS    8'h54
`define PIOC_OFS_OD_STAT   8'h58
// Reset values
`define PIOC_RST_ZERO      32'h0000_0000
`define PIOC_RST_OWN       32'hffff_ffff
`endif

/* File: core/pioc_pkg.sv */
package pioc_pkg;
	// Avalon-MM request bundle
	typedef struct packed {
		logic [7:0]  addr;
		logic        rd;
		logic        wr;
		logic [31:0] wdata;
	} pioc_req_type;
	// Bus slave phase
	typedef enum logic [0:0] {
		PIOC_IDLE,
		PIOC_DONE
	} pioc_bus_type;
endpackage

/* File: sim/pioc_pin_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Far-side pin model
// ----------------------------------------
module pioc_pin_model #(
	parameter int WIDTH = 32
) (
	input  wire logic [WIDTH-1:0] i_pin_out,
	input  wire logic [WIDTH-1:0] i_pin_oe_n,
	input  wire logic [WIDTH-1:0] i_ext_val,
	output logic      [WIDTH-1:0] o_level
);
	// A released pin follows the external side; its idle value is the
	// pull-up, so a released open-drain line reads high, never stale data
	always_comb begin
		for (int k = 0; k < WIDTH; k++) begin
			o_level[k] = i_pin_oe_n[k] ? i_ext_val[k] : i_pin_out[k];
		end
	end
endmodule

/* File: sim/tb.sv */
`timescale 1ns/100ps
`include "pioc_consts.svh"
module tb;
	logic        i_clk;
	logic        i_rst_n;
	logic [7:0]  i_avs_address;
	logic        i_avs_read;
	logic        i_avs_write;
	logic [31:0] i_avs_writedata;
	logic [31:0] o_avs_readdata;
	logic        o_avs_waitrequest;
	logic [31:0] i_pin;
	logic [31:0] o_pin;
	logic [31:0] o_pin_oe_n;
	logic [31:0] i_periph_out;
	logic [31:0] i_periph_oe;
	logic [31:0] o_periph_in;
	logic        o_irq;
	logic [31:0] ext_val;
	int          err_total;
	int          checks_done;

	pioc_top #(.WIDTH(32)) u_pioc_top (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .i_pin(i_pin), .o_pin(o_pin),
		.o_pin_oe_n(o_pin_oe_n), .i_periph_out(i_periph_out),
		.i_periph_oe(i_periph_oe), .o_periph_in(o_periph_in), .o_irq(o_irq)
	);
	pioc_pin_model #(.WIDTH(32)) u_pioc_pin_model (
		.i_pin_out(o_pin), .i_pin_oe_n(o_pin_oe_n),
		.i_ext_val(ext_val), .o_level(i_pin)
	);

	// Free-running 100 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Request held until waitrequest is seen low at a rising edge; the
	// values read right after the edge are the pre-edge ones
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge i_clk);
		i_avs_address <= a;
		i_avs_write <= w;
		i_avs_read <= ~w;
		i_avs_writedata <= d;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 20);
		q = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		if (n >= 20) begin
			err_total++;
			$display("MISMATCH t=%0t bus answer missing", $time);
			give_verdict();
		end
	endtask

	task automatic wrt(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		cmp(q, exp);
	endtask

	// Pin path settles within three edges; four leaves margin
	task automatic w4();
		repeat (4) @(posedge i_clk);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		i_rst_n = 1'b0;
		i_avs_address = 8'h00;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_writedata = 32'h0000_0000;
		i_periph_out = 32'h0000_0000;
		i_periph_oe = 32'h0000_0000;
		ext_val = 32'hffff_ffff;
		err_total = 0;
		checks_done = 0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		cmp(o_periph_in, 32'h0000_0000);
		rdc(`PIOC_OFS_FLT_STAT, 32'h0000_0000);
		rdc(`PIOC_OFS_OUT_STAT, 32'h0000_0000);
		rdc(`PIOC_OFS_IRQ_MASK, 32'h0000_0000);
		rdc(`PIOC_OFS_OD_STAT, 32'h0000_0000);
		rdc(8'h5c, 32'h0000_0000);
		wrt(`PIOC_OFS_FLT_EN, 32'h0000_00ff);
		wrt(`PIOC_OFS_FLT_DIS, 32'h0000_000f);
		rdc(`PIOC_OFS_FLT_STAT, 32'h0000_00f0);
		// Data written before the drivers are on is only stored
		wrt(`PIOC_OFS_OUT_SET, 32'h0000_00a5);
		wrt(`PIOC_OFS_OUT_CLR, 32'h0000_0005);
		rdc(`PIOC_OFS_OUT_STAT, 32'h0000_00a0);
		cmp(o_pin_oe_n, 32'hffff_ffff);
		wrt(`PIOC_OFS_DRV_EN, 32'h0000_00ff);
		rdc(`PIOC_OFS_DRV_STAT, 32'h0000_00ff);
		w4();
		cmp(o_pin_oe_n, 32'hffff_ff00);
		cmp(o_pin & 32'h0000_00ff, 32'h0000_00a0);
		rdc(`PIOC_OFS_PIN_STAT, 32'hffff_ffa0);
		// Hand pins 8 and 10 to the peripheral, which drives pin 10 high
		wrt(`PIOC_OFS_OWN_DIS, 32'h0000_0500);
		i_periph_oe <= 32'h0000_0400;
		i_periph_out <= 32'h0000_0400;
		w4();
		cmp(o_periph_in, 32'h0000_0500);
		cmp(o_pin_oe_n & 32'h0000_0400, 32'h0000_0000);
		rdc(`PIOC_OFS_IRQ_STAT, 32'h0000_005f);
		wrt(`PIOC_OFS_IRQ_EN, 32'h0000_0100);
		rdc(`PIOC_OFS_IRQ_MASK, 32'h0000_0100);
		ext_val[9] <= 1'b0;
		w4();
		cmp({31'h0, o_irq}, 32'h0000_0000);
		ext_val[8] <= 1'b0;
		w4();
		cmp({31'h0, o_irq}, 32'h0000_0001);
		rdc(`PIOC_OFS_IRQ_STAT, 32'h0000_0300);
		rdc(`PIOC_OFS_IRQ_STAT, 32'h0000_0000);
		cmp({31'h0, o_irq}, 32'h0000_0000);
		wrt(`PIOC_OFS_IRQ_DIS, 32'h0000_0100);
		rdc(`PIOC_OFS_IRQ_MASK, 32'h0000_0000);
		ext_val[8] <= 1'b1;
		w4();
		cmp({31'h0, o_irq}, 32'h0000_0000);
		rdc(`PIOC_OFS_IRQ_STAT, 32'h0000_0100);
		// One-cycle low pulses: pin 12 filtered, pin 13 not
		wrt(`PIOC_OFS_FLT_EN, 32'h0000_1000);
		@(posedge i_clk);
		ext_val[13:12] <= 2'b00;
		@(posedge i_clk);
		ext_val[13:12] <= 2'b11;
		w4();
		rdc(`PIOC_OFS_IRQ_STAT, 32'h0000_2000);
		wrt(`PIOC_OFS_OD_EN, 32'h0000_0001);
		rdc(`PIOC_OFS_OD_STAT, 32'h0000_0001);
		cmp(o_pin_oe_n & 32'h0000_0001, 32'h0000_0000);
		wrt(`PIOC_OFS_OUT_SET, 32'h0000_0001);
		w4();
		cmp(o_pin_oe_n & 32'h0000_0001, 32'h0000_0001);
		wrt(`PIOC_OFS_OD_DIS, 32'h0000_0001);
		rdc(`PIOC_OFS_OD_STAT, 32'h0000_0000);
		w4();
		cmp(o_pin_oe_n & 32'h0000_0001, 32'h0000_0000);
		cmp(o_pin & 32'h0000_0001, 32'h0000_0001);
		give_verdict();
	end
endmodule
